// >>> rtl/tcc_pkg.sv
// Shared constants and types for the 16-bit counter with input capture.
package tcc_pkg;

  // Register byte addresses on the APB.
  localparam logic [7:0] TCC_CTRL_A_OFF = 8'h00;
  localparam logic [7:0] TCC_CTRL_B_OFF = 8'h04;
  localparam logic [7:0] TCC_CNT_LO_OFF = 8'h08;
  localparam logic [7:0] TCC_CNT_HI_OFF = 8'h0c;
  localparam logic [7:0] TCC_CAP_LO_OFF = 8'h10;
  localparam logic [7:0] TCC_CAP_HI_OFF = 8'h14;
  localparam logic [7:0] TCC_CMPA_LO_OFF = 8'h18;
  localparam logic [7:0] TCC_CMPA_HI_OFF = 8'h1c;
  localparam logic [7:0] TCC_CMPB_LO_OFF = 8'h20;
  localparam logic [7:0] TCC_CMPB_HI_OFF = 8'h24;
  localparam logic [7:0] TCC_MASK_OFF = 8'h28;
  localparam logic [7:0] TCC_FLAG_OFF = 8'h2c;

  // Field positions inside the control, mask and flag registers.
  localparam int TCC_B_CS_LSB = 0;
  localparam int TCC_B_WGM_LSB = 3;
  localparam int TCC_B_SRC_BIT = 5;
  localparam int TCC_B_EDGE_BIT = 6;
  localparam int TCC_B_NC_BIT = 7;
  localparam int TCC_OVF_BIT = 0;
  localparam int TCC_CAP_BIT = 5;

  // Values after reset.
  localparam logic [7:0] TCC_CTRL_RST = 8'h00;
  localparam logic [15:0] TCC_WORD_RST = 16'h0000;

  // Fixed count limits.
  localparam logic [15:0] TCC_MAX = 16'hffff;
  localparam logic [15:0] TCC_TOP_8 = 16'h00ff;
  localparam logic [15:0] TCC_TOP_9 = 16'h01ff;
  localparam logic [15:0] TCC_TOP_10 = 16'h03ff;

  // Prescaler taps, as cycle counts minus one.
  localparam logic [9:0] TCC_DIV8 = 10'h007;
  localparam logic [9:0] TCC_DIV64 = 10'h03f;
  localparam logic [9:0] TCC_DIV256 = 10'h0ff;
  localparam logic [9:0] TCC_DIV1024 = 10'h3ff;

  // Noise canceler sample count.
  localparam int TCC_NC_SAMPLES = 4;

  // Clock source choices.
  typedef enum logic [2:0] {
    TCC_CS_STOP = 3'b000,
    TCC_CS_DIV1 = 3'b001,
    TCC_CS_DIV8 = 3'b010,
    TCC_CS_DIV64 = 3'b011,
    TCC_CS_DIV256 = 3'b100,
    TCC_CS_DIV1024 = 3'b101,
    TCC_CS_EXT_FALL = 3'b110,
    TCC_CS_EXT_RISE = 3'b111
  } tcc_cs_e;

  // Whole state of the timer, registered in one place.
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [15:0] count_value;
    logic [15:0] captured_count;
    logic [15:0] cmpa;
    logic [15:0] cmpb;
    logic [7:0] hold;
    logic [7:0] snap;
    logic [7:0] mask;
    logic overflow_flag;
    logic capture_flag;
    logic count_down;
    logic [9:0] presc;
    logic ext_prev;
    logic [3:0] nc_hist;
    logic cap_level;
    logic [31:0] rdata;
    logic rerr;
  } tcc_state_s;

endpackage

// >>> rtl/tcc_timer.sv
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module tcc_timer
  import tcc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event inputs.
  input wire logic ext_clock_pin,
  input wire logic capture_input_pin,
  input wire logic comparator_output,
  // Interrupt requests and acknowledges.
  output logic overflow_irq,
  output logic capture_irq,
  input wire logic overflow_irq_ack,
  input wire logic capture_irq_ack,
  // Count state indications.
  output logic count_at_top,
  output logic count_at_bottom
);

  // Current and next state.
  tcc_state_s state_reg;
  tcc_state_s state_next;

  // Every register of the block lives in the one state struct, so reset
  // and the clock edge touch it in a single place. The decode processes
  // below only look at the current state and the pins; the next-state
  // process then builds the whole new state from them.
  // A byte write to any upper location only loads the shared holding
  // latch, and a later lower-byte write moves latch and byte together.
  // This keeps a sixteen-bit update atomic on an eight-bit data path.
  // Software that shares the latch with an interrupt handler must keep
  // its two byte accesses together, since the latch is never saved.

  // Returns the top value for a waveform mode.
  function automatic logic [15:0] top_of(input logic [3:0] mode,
                                         input logic [15:0] ocra,
                                         input logic [15:0] icr);
    case (mode)
      // Fixed tops of eight, nine and ten bits.
      4'h1, 4'h5: top_of = TCC_TOP_8;
      4'h2, 4'h6: top_of = TCC_TOP_9;
      4'h3, 4'h7: top_of = TCC_TOP_10;
      // Compare register A sets the top.
      4'h4, 4'h9, 4'hb, 4'hf: top_of = ocra;
      // The capture register sets the top.
      4'h8, 4'ha, 4'hc, 4'he: top_of = icr;
      // Normal mode and the reserved code run to the maximum.
      default: top_of = TCC_MAX;
    endcase
  endfunction

  // True when the mode uses the capture register as its top.
  // Capture events are ignored in these modes.
  function automatic logic icr_is_top(input logic [3:0] mode);
    icr_is_top = (mode == 4'h8) || (mode == 4'ha) ||
                 (mode == 4'hc) || (mode == 4'he);
  endfunction

  // True when the mode counts up then down.
  // Overflow then falls at the bottom turn.
  function automatic logic dual_slope(input logic [3:0] mode);
    case (mode)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb: dual_slope = 1'b1;
      default: dual_slope = 1'b0;
    endcase
  endfunction

  // True when the mode clears on a top match.
  // These modes overflow only at the maximum count.
  function automatic logic ctc_mode(input logic [3:0] mode);
    ctc_mode = (mode == 4'h4) || (mode == 4'hc);
  endfunction

  // Decoded controls.
  // Four-bit waveform mode gathered from both control registers.
  logic [3:0] wave_mode;
  // Three-bit choice of the count clock.
  logic [2:0] clock_source_select;
  // Highest value of the count sequence in the current mode.
  logic [15:0] top_value;
  // One-cycle timer tick from the chosen source.
  logic tick;
  // Raw capture input after the source choice.
  logic cap_src;
  // Capture level after the optional noise filter.
  logic cap_filtered;
  // A qualified capture edge in this cycle.
  logic cap_event;
  // Access cycle of a write.
  logic wr_done;
  // Access cycle of a read.
  logic rd_done;
  // Setup cycle of any transfer.
  logic setup;

  // Split the control registers into their fields.
  always_comb begin
    wave_mode = {state_reg.ctrl_b[TCC_B_WGM_LSB +: 2],
                 state_reg.ctrl_a[1:0]};
    clock_source_select = state_reg.ctrl_b[TCC_B_CS_LSB +: 3];
    top_value = top_of(wave_mode, state_reg.cmpa,
                       state_reg.captured_count);
    // Pin or comparator as capture source.
    cap_src = state_reg.ctrl_b[TCC_B_SRC_BIT] ? comparator_output
                                              : capture_input_pin;
  end

  // APB phases; the slave answers in the first access cycle.
  // The setup cycle latches read data and the error bit.
  assign setup = psel && !penable;
  // Side effects need the access cycle, never the setup cycle.
  assign wr_done = psel && penable && pwrite;
  assign rd_done = psel && penable && !pwrite;
  // No wait states, so ready simply marks the access cycle.
  assign pready = psel && penable;
  assign prdata = state_reg.rdata;
  // Error shows only in the access cycle of an unmapped address.
  assign pslverr = psel && penable && state_reg.rerr;

  // Outputs straight from state.
  // Interrupt requests are each flag gated by its mask bit.
  assign count_at_top = (state_reg.count_value == top_value);
  assign count_at_bottom = (state_reg.count_value == TCC_WORD_RST);
  assign overflow_irq = state_reg.overflow_flag &&
                        state_reg.mask[TCC_OVF_BIT];
  assign capture_irq = state_reg.capture_flag &&
                       state_reg.mask[TCC_CAP_BIT];

  // Timer tick from the selected clock source.
  always_comb begin
    case (tcc_cs_e'(clock_source_select))
      TCC_CS_STOP: tick = 1'b0;
      // Undivided system clock.
      TCC_CS_DIV1: tick = 1'b1;
      // Prescaler taps; the prescaler rests at zero while stopped.
      TCC_CS_DIV8: tick = (state_reg.presc[2:0] == TCC_DIV8[2:0]);
      TCC_CS_DIV64: tick = (state_reg.presc[5:0] == TCC_DIV64[5:0]);
      TCC_CS_DIV256: tick = (state_reg.presc[7:0] == TCC_DIV256[7:0]);
      TCC_CS_DIV1024: tick = (state_reg.presc == TCC_DIV1024);
      // Edges of the external pin against its previous sample.
      TCC_CS_EXT_FALL: tick = state_reg.ext_prev && !ext_clock_pin;
      TCC_CS_EXT_RISE: tick = !state_reg.ext_prev && ext_clock_pin;
      // Unreachable with a three-bit field.
      default: tick = 1'b0;
    endcase
  end

  // Filtered capture level and edge detection.
  always_comb begin
    if (state_reg.ctrl_b[TCC_B_NC_BIT]) begin
      // All samples must agree before the level moves.
      if (&state_reg.nc_hist) begin
        cap_filtered = 1'b1;
      end else if (~|state_reg.nc_hist) begin
        cap_filtered = 1'b0;
      end else begin
        cap_filtered = state_reg.cap_level;
      end
    end else begin
      // Without the canceler the newest sample is the level.
      cap_filtered = state_reg.nc_hist[0];
    end
    // Edge must match the chosen polarity; off when capture is top.
    cap_event = !icr_is_top(wave_mode) &&
                (cap_filtered != state_reg.cap_level) &&
                (cap_filtered == state_reg.ctrl_b[TCC_B_EDGE_BIT]);
  end

  // Next-state logic for counter, capture, latch and registers.
  always_comb begin
    logic ovf_set;
    ovf_set = 1'b0;
    state_next = state_reg;

    // Prescaler runs while any source is chosen.
    // Holding it at zero while stopped makes the first divided tick
    // come a full period after the clock is started.
    if (clock_source_select == TCC_CS_STOP) begin
      state_next.presc = 10'h000;
    end else begin
      state_next.presc = state_reg.presc + 10'h001;
    end
    state_next.ext_prev = ext_clock_pin;

    // Counting on each tick.
    if (tick) begin
      if (dual_slope(wave_mode)) begin
        // Up to top, then back down to zero.
        if (!state_reg.count_down) begin
          // Turn at the top, or at once if the count was written above it.
          if (state_reg.count_value >= top_value) begin
            state_next.count_down = 1'b1;
            state_next.count_value = state_reg.count_value - 16'h0001;
          end else begin
            state_next.count_value = state_reg.count_value + 16'h0001;
          end
        end else if (state_reg.count_value == TCC_WORD_RST) begin
          // Turn at the bottom; this is where overflow is flagged.
          state_next.count_down = 1'b0;
          state_next.count_value = 16'h0001;
          ovf_set = 1'b1;
        end else begin
          state_next.count_value = state_reg.count_value - 16'h0001;
        end
      end else begin
        // Single slope: wrap to zero at top.
        state_next.count_down = 1'b0;
        if (state_reg.count_value == top_value) begin
          state_next.count_value = TCC_WORD_RST;
        end else begin
          state_next.count_value = state_reg.count_value + 16'h0001;
        end
        // Clear-on-match modes overflow only at the maximum.
        if (ctc_mode(wave_mode)) begin
          ovf_set = (state_reg.count_value == TCC_MAX);
        end else begin
          ovf_set = (state_reg.count_value == top_value);
        end
      end
    end

    // Capture filter history and edge tracking.
    // The history shifts every cycle; a capture copies the held count.
    state_next.nc_hist = {state_reg.nc_hist[TCC_NC_SAMPLES-2:0], cap_src};
    state_next.cap_level = cap_filtered;
    if (cap_event) begin
      state_next.captured_count = state_reg.count_value;
    end

    // Read data and error captured in the setup cycle.
    if (setup) begin
      state_next.rerr = 1'b0;
      state_next.rdata = 32'h0000_0000;
      case (paddr)
        // Control registers read back as written.
        TCC_CTRL_A_OFF: state_next.rdata[7:0] = state_reg.ctrl_a;
        TCC_CTRL_B_OFF: state_next.rdata[7:0] = state_reg.ctrl_b;
        TCC_CNT_LO_OFF: begin
          // The upper byte waits in the snapshot until the access edge.
          state_next.rdata[7:0] = state_reg.count_value[7:0];
          state_next.snap = state_reg.count_value[15:8];
        end
        TCC_CAP_LO_OFF: begin
          state_next.rdata[7:0] = state_reg.captured_count[7:0];
          state_next.snap = state_reg.captured_count[15:8];
        end
        // Upper count and capture locations read the latch.
        TCC_CNT_HI_OFF, TCC_CAP_HI_OFF:
          state_next.rdata[7:0] = state_reg.hold;
        // Compare registers read both bytes directly.
        TCC_CMPA_LO_OFF: state_next.rdata[7:0] = state_reg.cmpa[7:0];
        TCC_CMPA_HI_OFF: state_next.rdata[7:0] = state_reg.cmpa[15:8];
        TCC_CMPB_LO_OFF: state_next.rdata[7:0] = state_reg.cmpb[7:0];
        TCC_CMPB_HI_OFF: state_next.rdata[7:0] = state_reg.cmpb[15:8];
        TCC_MASK_OFF: state_next.rdata[7:0] = state_reg.mask;
        TCC_FLAG_OFF: begin
          // Only the two flag bits exist; the rest read as zero.
          state_next.rdata[TCC_OVF_BIT] = state_reg.overflow_flag;
          state_next.rdata[TCC_CAP_BIT] = state_reg.capture_flag;
        end
        // Unmapped addresses answer with an error and zero data.
        default: state_next.rerr = 1'b1;
      endcase
    end

    // Read side effect: a count or capture lower byte read fills the shared latch.
    if (rd_done && ((paddr == TCC_CNT_LO_OFF) ||
                    (paddr == TCC_CAP_LO_OFF))) begin
      state_next.hold = state_reg.snap;
    end

    // Writes take effect at the completing edge.
    if (wr_done) begin
      case (paddr)
        // Control registers take the low byte of the write data.
        TCC_CTRL_A_OFF: state_next.ctrl_a = pwdata[7:0];
        TCC_CTRL_B_OFF: state_next.ctrl_b = pwdata[7:0];
        // Every upper location writes the one shared latch.
        TCC_CNT_HI_OFF, TCC_CAP_HI_OFF, TCC_CMPA_HI_OFF,
        TCC_CMPB_HI_OFF: state_next.hold = pwdata[7:0];
        TCC_CNT_LO_OFF: begin
          // Overrides any count or clear in this cycle.
          state_next.count_value = {state_reg.hold, pwdata[7:0]};
          state_next.count_down = state_reg.count_down;
        end
        TCC_CAP_LO_OFF: begin
          // Ignored without an error outside the capture-top modes.
          if (icr_is_top(wave_mode)) begin
            state_next.captured_count = {state_reg.hold,
                                         pwdata[7:0]};
          end
        end
        // Compare registers load latch and byte together.
        TCC_CMPA_LO_OFF: state_next.cmpa = {state_reg.hold, pwdata[7:0]};
        TCC_CMPB_LO_OFF: state_next.cmpb = {state_reg.hold, pwdata[7:0]};
        TCC_MASK_OFF: state_next.mask = pwdata[7:0];
        TCC_FLAG_OFF: begin
          // Writing one clears; zero leaves the flag alone.
          if (pwdata[TCC_OVF_BIT]) begin
            state_next.overflow_flag = 1'b0;
          end
          if (pwdata[TCC_CAP_BIT]) begin
            state_next.capture_flag = 1'b0;
          end
        end
        // Unmapped writes change nothing; the error came from setup.
        default: state_next.rerr = state_reg.rerr;
      endcase
    end

    // Interrupt acknowledges clear their flag.
    // An acknowledge is a one-cycle pulse from the interrupt logic.
    if (overflow_irq_ack) begin
      state_next.overflow_flag = 1'b0;
    end
    if (capture_irq_ack) begin
      state_next.capture_flag = 1'b0;
    end

    // Hardware sets win over any clear in the same cycle.
    if (ovf_set) begin
      state_next.overflow_flag = 1'b1;
    end
    if (cap_event) begin
      state_next.capture_flag = 1'b1;
    end
  end

  // State register; all fields clear at reset so the timer is stopped.
  // Only constants appear in the reset branch, so the asynchronous
  // reset path stays free of any logic.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule

// >>> verification/tcc_timer_monitor.sv
`timescale 1ns/10ps
// Port watcher for bus timing and interrupt causes.
module tcc_timer_monitor (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events, requests and indications.
  input wire logic capture_input_pin,
  input wire logic comparator_output,
  input wire logic overflow_irq,
  input wire logic capture_irq,
  input wire logic capture_irq_ack,
  input wire logic count_at_top,
  input wire logic count_at_bottom
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // High during a write access phase.
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  // Event inputs one cycle ago.
  logic cap_d;
  logic cmp_d;
  // Cycles since an event input moved or a write; saturates.
  logic [3:0] quiet;
  // A capture may only follow an input change or a write closely.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_d <= 1'b0;
      cmp_d <= 1'b0;
      quiet <= 4'h0;
    end else begin
      cap_d <= capture_input_pin;
      cmp_d <= comparator_output;
      if (wr_acc || capture_input_pin != cap_d || comparator_output != cmp_d)
        quiet <= 4'h0;
      else if (quiet != 4'hf)
        quiet <= quiet + 4'h1;
    end
  end
  a_ready_now: assert property (pready == (psel && penable))
    else $error("pready not equal to access phase");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  a_err_no_data: assert property (pslverr |-> prdata == 32'h0)
    else $error("read data not zero on error");
  a_read_holds: assert property (psel && penable && !pwrite |=>
    prdata == $past(prdata))
    else $error("read data moved after access");
  a_reset_idle: assert property ($rose(rst_b) |-> count_at_bottom &&
    !count_at_top && !capture_irq && !overflow_irq)
    else $error("state not cleared by reset");
  a_cap_has_edge: assert property ($rose(capture_irq) |-> quiet <= 4'h8)
    else $error("capture request with no input edge");
  a_cap_drop_cause: assert property ($fell(capture_irq) |->
    $past(capture_irq_ack) || $past(wr_acc))
    else $error("capture request fell with no cause");
  a_ovf_has_cause: assert property ($rose(overflow_irq) |->
    $past(wr_acc) || $past(count_at_top) || $past(count_at_bottom) ||
    count_at_bottom)
    else $error("overflow request away from top or bottom");
  c_capture: cover property ($rose(capture_irq));
  c_overflow: cover property ($rose(overflow_irq));
  c_refused: cover property (pslverr);
endmodule

bind tcc_timer tcc_timer_monitor i_tcc_timer_monitor (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .capture_input_pin(capture_input_pin),
  .comparator_output(comparator_output), .overflow_irq(overflow_irq),
  .capture_irq(capture_irq), .capture_irq_ack(capture_irq_ack),
  .count_at_top(count_at_top), .count_at_bottom(count_at_bottom));

// >>> verification/tcc_cpu_model.sv
`timescale 1ns/10ps
// CPU side: one byte transfer at a time over APB, never interleaved.
module tcc_cpu_model (
  // Clock.
  input wire logic clk,
  // Bus.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Error response of the last transfer.
  logic err;
  // Bus idle at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Setup, then access held until pready; one request in flight.
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~{24'h000000, d};
  endtask
  // Byte write.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  // Byte read.
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 8'h00, q);
  endtask
  // Word write: upper location before lower, nothing in between.
  task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
    wr(lo + 8'h04, v[15:8]);
    wr(lo, v[7:0]);
  endtask
endmodule

// >>> verification/tcc_timer_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("Error %s expected %h seen %h", nm, e, g); \
  end \
end
module tcc_timer_bench
  import tcc_pkg::*;
;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic ext, cap, cmp, oack, cack, oirq, cirq, top, bot;
  int err_total, n_tests, cyc, i;
  // Offsets whose reset value is zero.
  logic [7:0] offs [8] = '{TCC_CTRL_A_OFF, TCC_CTRL_B_OFF, TCC_CNT_LO_OFF,
    TCC_CNT_HI_OFF, TCC_CAP_LO_OFF, TCC_CAP_HI_OFF, TCC_MASK_OFF,
    TCC_FLAG_OFF};
  tcc_cpu_model i_tcc_cpu_model (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  tcc_timer i_tcc_timer (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_pin(ext), .capture_input_pin(cap), .comparator_output(cmp),
    .overflow_irq(oirq), .capture_irq(cirq), .overflow_irq_ack(oack),
    .capture_irq_ack(cack), .count_at_top(top), .count_at_bottom(bot));
  // 50 ns clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Verdict and end of run.
  task automatic give_verdict();
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard; the tests need under a thousand cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      err_total++;
      give_verdict();
    end
  end
  // Let n edges pass.
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Byte write, then one edge so the effect is visible.
  task automatic w8(input logic [7:0] a, input logic [7:0] d);
    i_tcc_cpu_model.wr(a, d);
    tk(1);
  endtask
  // Byte read compared with an expected value.
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] v;
    i_tcc_cpu_model.rd(a, v);
    `CHK($sformatf("reg %h", a), {24'h000000, e}, v)
  endtask
  // Main sequence.
  initial begin
    {rst_b, ext, cap, cmp, oack, cack} = 6'h00;
    tk(10);
    rst_b <= 1'b1;
    for (i = 0; i < 8; i++) rc(offs[i], 8'h00);
    `CHK("bottom", 1'b1, bot)
    // Stopped count keeps written word; upper goes through latch.
    i_tcc_cpu_model.wr16(TCC_CNT_LO_OFF, 16'h01ff);
    tk(20);
    rc(TCC_CNT_LO_OFF, 8'hff);
    rc(TCC_CNT_HI_OFF, 8'h01);
    // One upper byte serves two compare writes.
    w8(TCC_CMPA_HI_OFF, 8'h12);
    w8(TCC_CMPA_LO_OFF, 8'h34);
    w8(TCC_CMPB_LO_OFF, 8'h56);
    rc(TCC_CNT_LO_OFF, 8'hff);
    rc(TCC_CMPA_HI_OFF, 8'h12);
    rc(TCC_CMPB_HI_OFF, 8'h12);
    rc(TCC_CNT_HI_OFF, 8'h01);
    // Unmapped place is refused.
    i_tcc_cpu_model.rd(8'h30, q);
    `CHK("slave error", 1'b1, i_tcc_cpu_model.err)
    // Dual slope with fixed top 00ff, full rate: up, then down to zero.
    i_tcc_cpu_model.wr16(TCC_CNT_LO_OFF, 16'h0000);
    w8(TCC_MASK_OFF, 8'h01);
    w8(TCC_CTRL_A_OFF, 8'h01);
    w8(TCC_CTRL_B_OFF, 8'h01);
    for (i = 0; i < 2000 && top !== 1'b1; i++) tk(1);
    `CHK("top", 1'b1, top)
    for (i = 0; i < 2000 && bot !== 1'b1; i++) tk(1);
    `CHK("down count", 1'b1, bot === 1'b1 && i > 200)
    tk(3);
    `CHK("overflow irq", 1'b1, oirq)
    w8(TCC_CTRL_B_OFF, 8'h00);
    rc(TCC_FLAG_OFF, 8'h01);
    w8(TCC_FLAG_OFF, 8'h01);
    `CHK("overflow cleared", 1'b0, oirq)
    // External rising edges counted in normal mode.
    w8(TCC_CTRL_A_OFF, 8'h00);
    i_tcc_cpu_model.wr16(TCC_CNT_LO_OFF, 16'h0000);
    w8(TCC_CTRL_B_OFF, 8'h07);
    for (i = 0; i < 5; i++) begin
      ext <= 1'b1;
      tk(2);
      ext <= 1'b0;
      tk(2);
    end
    tk(3);
    w8(TCC_CTRL_B_OFF, 8'h00);
    rc(TCC_CNT_LO_OFF, 8'h05);
    // Divide by eight: ten ticks in the 83 cycles the clock is on.
    i_tcc_cpu_model.wr16(TCC_CNT_LO_OFF, 16'h0000);
    w8(TCC_CTRL_B_OFF, 8'h02);
    tk(79);
    w8(TCC_CTRL_B_OFF, 8'h00);
    rc(TCC_CNT_LO_OFF, 8'h0a);
    // Pin rising edge captures the held count.
    i_tcc_cpu_model.wr16(TCC_CNT_LO_OFF, 16'habcd);
    w8(TCC_MASK_OFF, 8'h20);
    w8(TCC_CTRL_B_OFF, 8'h40);
    cap <= 1'b1;
    tk(5);
    `CHK("capture irq", 1'b1, cirq)
    rc(TCC_FLAG_OFF, 8'h20);
    rc(TCC_CAP_LO_OFF, 8'hcd);
    rc(TCC_CAP_HI_OFF, 8'hab);
    // Falling edge is not the chosen one.
    i_tcc_cpu_model.wr16(TCC_CNT_LO_OFF, 16'h1111);
    cap <= 1'b0;
    tk(5);
    rc(TCC_CAP_LO_OFF, 8'hcd);
    w8(TCC_FLAG_OFF, 8'h00);
    `CHK("flag kept", 1'b1, cirq)
    w8(TCC_FLAG_OFF, 8'h20);
    `CHK("flag cleared", 1'b0, cirq)
    // Comparator falling edge as the source; ack clears the flag.
    cmp <= 1'b1;
    i_tcc_cpu_model.wr16(TCC_CNT_LO_OFF, 16'h2233);
    w8(TCC_CTRL_B_OFF, 8'h20);
    tk(5);
    w8(TCC_FLAG_OFF, 8'h20);
    cmp <= 1'b0;
    tk(5);
    `CHK("comparator irq", 1'b1, cirq)
    rc(TCC_CAP_LO_OFF, 8'h33);
    rc(TCC_CAP_HI_OFF, 8'h22);
    cack <= 1'b1;
    tk(1);
    cack <= 1'b0;
    tk(1);
    `CHK("ack cleared", 1'b0, cirq)
    // Capture word writable only where it sets the top.
    w8(TCC_CTRL_B_OFF, 8'h00);
    i_tcc_cpu_model.wr16(TCC_CAP_LO_OFF, 16'h5555);
    rc(TCC_CAP_LO_OFF, 8'h33);
    w8(TCC_CTRL_B_OFF, 8'h18);
    i_tcc_cpu_model.wr16(TCC_CAP_LO_OFF, 16'h0077);
    rc(TCC_CAP_LO_OFF, 8'h77);
    i_tcc_cpu_model.wr16(TCC_CNT_LO_OFF, 16'h0077);
    tk(1);
    `CHK("capture top", 1'b1, top)
    // Clear-on-match mode overflows only at the maximum; ack clears it.
    w8(TCC_MASK_OFF, 8'h21);
    i_tcc_cpu_model.wr16(TCC_CNT_LO_OFF, 16'hffff);
    w8(TCC_CTRL_B_OFF, 8'h19);
    tk(3);
    `CHK("ctc overflow", 1'b1, oirq)
    oack <= 1'b1;
    tk(1);
    oack <= 1'b0;
    tk(1);
    `CHK("overflow ack", 1'b0, oirq)
    give_verdict();
  end
endmodule
